/* File: inc/i2cms_pkg.sv */
// i2cms_pkg: register map, field positions, reset values and states
// for the i2c master start-condition block.
// assumes a plain one-cycle strobe register port, 8-bit data.
package i2cms_pkg;

    // --------------------------------------------------------------
    // register offsets
    // --------------------------------------------------------------
    localparam logic [2:0] ADDR_CTRL2   = 3'h0; // serial_control_two
    localparam logic [2:0] ADDR_STATUS  = 3'h1; // serial_status
    localparam logic [2:0] ADDR_RELOAD  = 3'h2; // baud_reload_value
    localparam logic [2:0] ADDR_BUFFER  = 3'h3; // serial_data_buffer
    localparam logic [2:0] ADDR_IRQ_ST  = 3'h4; // sticky events, read only
    localparam logic [2:0] ADDR_IRQ_CLR = 3'h5; // write one to clear
    localparam logic [2:0] ADDR_IRQ_EN  = 3'h6; // interrupt enables

    // --------------------------------------------------------------
    // field positions
    // --------------------------------------------------------------
    localparam int CTRL2_START_BIT = 0;
    localparam int CTRL2_LOCK_W    = 5;
    localparam int STATUS_START_BIT = 3;
    localparam int STATUS_WRITE_COLLISION_FLAG_BIT  = 7;
    localparam int RELOAD_W         = 7;
    localparam int IRQ_BCOL_BIT     = 0;
    localparam int IRQ_WRITE_COLLISION_FLAG_BIT     = 1;
    localparam int IRQ_START_BIT    = 2;
    localparam int IRQ_DONE_BIT     = 3;
    localparam int IRQ_W            = 4;

    // --------------------------------------------------------------
    // reset values and the baud terminal count
    // --------------------------------------------------------------
    localparam logic [7:0] CTRL2_RST  = 8'h00;
    localparam logic [6:0] RELOAD_RST = 7'h00;
    localparam logic [7:0] BUFFER_RST = 8'h00;
    localparam logic [3:0] IRQ_RST    = 4'h0;
    localparam logic [6:0] BAUD_TERM  = 7'h7f;

    // --------------------------------------------------------------
    // sequencer states
    // --------------------------------------------------------------
    typedef enum logic [1:0] {
        ST_IDLE  = 2'b00,
        ST_SETUP = 2'b01,
        ST_HOLD  = 2'b10
    } i2cms_state_t;

endpackage

/* File: rtl/i2cms_baud.sv */
// i2cms_baud: baud rate generator for the start sequence.
// assumes the caller pulses load_i; counts up to terminal count.
`timescale 1ns/1ns
module i2cms_baud
    import i2cms_pkg::*;
(
    // clock and reset
    input  wire logic                clk_i,
    input  wire logic                rst_i,
    // control
    input  wire logic                load_i,
    input  wire logic                run_i,
    input  wire logic [RELOAD_W-1:0] reload_i,
    // status
    output logic                     tick_o
);
    import i2cms_pkg::*;

    typedef struct packed {
        logic [RELOAD_W-1:0] count;
    } i2cms_baud_t;

    i2cms_baud_t state_reg;
    i2cms_baud_t state_next;

    // tick while running at terminal count; no load term here, since the
    // caller derives its reload from this tick and that would close a loop
    assign tick_o = run_i && (state_reg.count == BAUD_TERM);

    always_comb begin
        state_next = state_reg;
        if (load_i) begin
            state_next.count = reload_i;
        end else if (run_i && state_reg.count != BAUD_TERM) begin
            state_next.count = state_reg.count + 7'h01;
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end
endmodule // i2cms_baud

/* File: rtl/i2cms_start.sv */
// i2cms_start: i2c master start-condition generator with registers.
// assumes sda/scl inputs are already synchronous; pins are open drain.
`timescale 1ns/1ns
module i2cms_start
    import i2cms_pkg::*;
(
    // clock and reset
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    // register port
    input  wire logic [2:0] addr_i,
    input  wire logic [7:0] wdata_i,
    input  wire logic       wr_i,
    input  wire logic       rd_i,
    output logic      [7:0] rdata_o,
    // i2c pins
    input  wire logic       sda_i,
    output logic            sda_o,
    output logic            sda_oe_o,
    input  wire logic       scl_i,
    output logic            scl_o,
    output logic            scl_oe_o,
    // interrupt
    output logic            irq_o
);
    import i2cms_pkg::*;

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    typedef struct packed {
        i2cms_state_t        st;
        logic [7:0]          ctrl2;
        logic [RELOAD_W-1:0] reload;
        logic [7:0]          buffer;
        logic                start_seen;
        logic                write_collision_flag;
        logic                sda_low;
        logic [IRQ_W-1:0]    irq_st;
        logic [IRQ_W-1:0]    irq_en;
        logic [7:0]          rdata;
    } i2cms_start_t;

    i2cms_start_t state_reg;
    i2cms_start_t state_next;

    logic baud_load;
    logic baud_run;
    logic baud_tick;

    function automatic logic is_wr(input logic [2:0] a);
        is_wr = wr_i && (addr_i == a);
    endfunction

    // ------------------------------------------------------------------
    // baud rate generator
    // ------------------------------------------------------------------
    i2cms_baud u_baud (
        .clk_i    (clk_i),
        .rst_i    (rst_i),
        .load_i   (baud_load),
        .run_i    (baud_run),
        .reload_i (state_reg.reload),
        .tick_o   (baud_tick)
    );

    // ------------------------------------------------------------------
    // sequencer and registers
    // ------------------------------------------------------------------
    always_comb begin
        logic [IRQ_W-1:0] ev;
        logic             busy;
        logic             sda_free;
        ev         = '0;
        // our own hold from the last start does not count as a busy line,
        // otherwise a second start would wait on itself for ever
        sda_free   = sda_i || state_reg.sda_low;
        state_next = state_reg;
        baud_load  = 1'b0;
        baud_run   = (state_reg.st != ST_IDLE);
        busy       = state_reg.ctrl2[CTRL2_START_BIT];

        // register writes; lock holds low control bits while busy
        if (is_wr(ADDR_CTRL2)) begin
            if (busy) begin
                state_next.ctrl2[7:CTRL2_LOCK_W] =
                    wdata_i[7:CTRL2_LOCK_W];
            end else begin
                state_next.ctrl2 = wdata_i;
            end
        end
        if (is_wr(ADDR_RELOAD)) begin
            state_next.reload = wdata_i[RELOAD_W-1:0];
        end
        if (is_wr(ADDR_BUFFER)) begin
            if (busy) begin
                ev[IRQ_WRITE_COLLISION_FLAG_BIT] = 1'b1;
                state_next.write_collision_flag  = 1'b1;
            end else begin
                state_next.buffer = wdata_i;
            end
        end
        if (is_wr(ADDR_STATUS) && !wdata_i[STATUS_WRITE_COLLISION_FLAG_BIT]) begin
            state_next.write_collision_flag = 1'b0;
        end

        case (state_reg.st)
            ST_IDLE: begin
                if (state_reg.ctrl2[CTRL2_START_BIT]) begin
                    if (sda_free && scl_i) begin
                        baud_load        = 1'b1;
                        state_next.st    = ST_SETUP;
                        state_next.start_seen = 1'b0;
                    end else if (!sda_i && !scl_i) begin
                        ev[IRQ_BCOL_BIT] = 1'b1;
                        state_next.sda_low = 1'b0;
                        state_next.ctrl2[CTRL2_START_BIT] = 1'b0;
                    end
                end
            end
            ST_SETUP: begin
                if (!scl_i) begin
                    // scl stolen before we pulled sda: lose arbitration
                    ev[IRQ_BCOL_BIT] = 1'b1;
                    state_next.ctrl2[CTRL2_START_BIT] = 1'b0;
                    state_next.st = ST_IDLE;
                end else if (baud_tick && sda_i) begin
                    state_next.sda_low    = 1'b1;
                    state_next.start_seen = 1'b1;
                    ev[IRQ_START_BIT]     = 1'b1;
                    baud_load             = 1'b1;
                    state_next.st         = ST_HOLD;
                end else if (baud_tick) begin
                    ev[IRQ_BCOL_BIT] = 1'b1;
                    state_next.ctrl2[CTRL2_START_BIT] = 1'b0;
                    state_next.st = ST_IDLE;
                end
            end
            ST_HOLD: begin
                if (baud_tick) begin
                    state_next.ctrl2[CTRL2_START_BIT] = 1'b0;
                    ev[IRQ_DONE_BIT] = 1'b1;
                    state_next.st    = ST_IDLE;
                end
            end
            default: begin
                state_next.st = ST_IDLE;
            end
        endcase

        // a new sequence releases a previously held sda
        if (baud_load && state_reg.st == ST_IDLE) begin
            state_next.sda_low = 1'b0;
        end

        // sticky events: set wins over clear
        if (is_wr(ADDR_IRQ_CLR)) begin
            state_next.irq_st = state_reg.irq_st & ~wdata_i[IRQ_W-1:0];
        end
        state_next.irq_st = state_next.irq_st | ev;
        if (is_wr(ADDR_IRQ_EN)) begin
            state_next.irq_en = wdata_i[IRQ_W-1:0];
        end

        // read data stands in the cycle after the strobe only
        state_next.rdata = 8'h00;
        if (rd_i) begin
            if (addr_i == ADDR_CTRL2) begin
                state_next.rdata = state_reg.ctrl2;
            end else if (addr_i == ADDR_STATUS) begin
                state_next.rdata[STATUS_START_BIT] = state_reg.start_seen;
                state_next.rdata[STATUS_WRITE_COLLISION_FLAG_BIT]  = state_reg.write_collision_flag;
            end else if (addr_i == ADDR_RELOAD) begin
                state_next.rdata = {1'b0, state_reg.reload};
            end else if (addr_i == ADDR_BUFFER) begin
                state_next.rdata = state_reg.buffer;
            end else if (addr_i == ADDR_IRQ_ST) begin
                state_next.rdata = {4'h0, state_reg.irq_st};
            end else if (addr_i == ADDR_IRQ_EN) begin
                state_next.rdata = {4'h0, state_reg.irq_en};
            end else begin
                state_next.rdata = 8'h00;
            end
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            state_reg.st         <= ST_IDLE;
            state_reg.ctrl2      <= CTRL2_RST;
            state_reg.reload     <= RELOAD_RST;
            state_reg.buffer     <= BUFFER_RST;
            state_reg.start_seen <= 1'b0;
            state_reg.write_collision_flag       <= 1'b0;
            state_reg.sda_low    <= 1'b0;
            state_reg.irq_st     <= IRQ_RST;
            state_reg.irq_en     <= IRQ_RST;
            state_reg.rdata      <= 8'h00;
        end else begin
            state_reg <= state_next;
        end
    end

    // ------------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------------
    // open drain: only ever drive low; scl is left released here
    assign sda_o    = 1'b0;
    assign sda_oe_o = state_reg.sda_low;
    assign scl_o    = 1'b0;
    assign scl_oe_o = 1'b0;
    assign rdata_o  = state_reg.rdata;
    assign irq_o    = |(state_reg.irq_st & state_reg.irq_en);
endmodule // i2cms_start

/* File: test/i2cms_bus_model.sv */
// i2cms_bus_model: two open-drain lines with pull-ups.
// assumes the bench commands a far-side hold of either line.
`timescale 1ns/1ns
module i2cms_bus_model (
    // design side
    input  wire logic sda_oe_i,
    input  wire logic scl_oe_i,
    // far-side holds
    input  wire logic hold_sda_i,
    input  wire logic hold_scl_i,
    // wire levels
    output logic      sda_o,
    output logic      scl_o
);
    // a released line floats up; any driver wins low
    assign sda_o = ~(sda_oe_i | hold_sda_i);
    assign scl_o = ~(scl_oe_i | hold_scl_i);
endmodule // i2cms_bus_model

/* File: test/i2cms_start_properties.sv */
// i2cms_start_properties: port checks of the start generator.
// assumes it is bound onto i2cms_start; one clock domain.
`timescale 1ns/1ns
module i2cms_start_properties
    import i2cms_pkg::*;
(
    input wire logic       clk_i,
    input wire logic       rst_i,
    input wire logic [2:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic       wr_i,
    input wire logic       rd_i,
    input wire logic [7:0] rdata_o,
    input wire logic       sda_i,
    input wire logic       sda_o,
    input wire logic       sda_oe_o,
    input wire logic       scl_i,
    input wire logic       scl_o,
    input wire logic       scl_oe_o,
    input wire logic       irq_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // ----------------------------------------------
    // mirrors of software writes and a start-write cycle count
    // ----------------------------------------------
    logic       go;
    logic [6:0] rl_reg;
    logic [3:0] en_reg;
    logic [7:0] cnt_reg;
    assign go = wr_i && addr_i == ADDR_CTRL2 && wdata_i[CTRL2_START_BIT];
    // cycles since a start write; saturates so a stuck run stays quiet
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            rl_reg <= RELOAD_RST;
            en_reg <= IRQ_RST;
            cnt_reg <= 8'h00;
        end else begin
            if (wr_i && addr_i == ADDR_RELOAD)
                rl_reg <= wdata_i[6:0];
            if (wr_i && addr_i == ADDR_IRQ_EN)
                en_reg <= wdata_i[3:0];
            if (go)
                cnt_reg <= 8'h01;
            else if (sda_oe_o && cnt_reg != 8'h01)
                cnt_reg <= 8'h00;
            else if (cnt_reg != 8'h00 && cnt_reg != 8'hff)
                cnt_reg <= cnt_reg + 8'h01;
        end
    end
    // ----------------------------------------------
    // properties
    // ----------------------------------------------
    sequence s_go;
        go;
    endsequence
    sequence s_both_low;
        !sda_i && !scl_i;
    endsequence
    a_scl_left_high: assert property (!scl_oe_o && !scl_o)
        else $error("scl driven");
    a_sda_open_drain: assert property (!sda_o)
        else $error("sda driven high");
    a_pull_lines_high: assert property ($rose(sda_oe_o) |->
        $past(sda_i) && $past(scl_i)) else $error("pull with line low");
    a_first_period: assert property ($rose(sda_oe_o) &&
        cnt_reg != 8'h00 |-> cnt_reg == 8'h82 - {1'b0, rl_reg})
        else $error("first period length wrong");
    a_collide_quiet: assert property (s_go ##1 s_both_low |->
        ##2 !sda_oe_o [*4]) else $error("sda pulled after collision");
    a_collide_irq: assert property (s_go ##1 s_both_low
        ##0 en_reg[IRQ_BCOL_BIT] |-> ##[1:3] irq_o)
        else $error("collision irq missing");
    a_oe_held: assert property ($fell(sda_oe_o) |-> $past(go) ||
        $past(go, 2) || $past(go, 3)) else $error("sda released early");
    a_irq_masked: assert property (en_reg == 4'h0 &&
        $past(en_reg) == 4'h0 |-> !irq_o) else $error("masked irq high");
    a_rdata_quiet: assert property (!$past(rd_i) |->
        rdata_o == 8'h00) else $error("read data without read");
endmodule // i2cms_start_properties

bind i2cms_start i2cms_start_properties u_props (.*);

/* File: test/i2cms_start_tb.sv */
// i2cms_start_tb: register-level tests of the start generator.
// assumes the bus model pulls both lines up.
`timescale 1ns/1ns
module i2cms_start_tb;
    import i2cms_pkg::*;
    logic       clk_i = 1'b0;
    logic       rst_i = 1'b1;
    logic       wr_i = 1'b0;
    logic       rd_i = 1'b0;
    logic       hold_sda = 1'b0;
    logic       hold_scl = 1'b0;
    logic [2:0] addr_i = 3'h0;
    logic [7:0] wdata_i = 8'h00;
    logic [7:0] rdata_o;
    logic [7:0] rq;
    logic       sda_i, scl_i, sda_oe_o, scl_oe_o, irq_o;
    int         fail_count = 0;
    int         total_checks = 0;
    int         cyc = 0;
    int         n;
    always #20 clk_i = ~clk_i;
    i2cms_start u_dut (.clk_i(clk_i), .rst_i(rst_i), .addr_i(addr_i),
        .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
        .sda_i(sda_i), .sda_o(), .sda_oe_o(sda_oe_o), .scl_i(scl_i),
        .scl_o(), .scl_oe_o(scl_oe_o), .irq_o(irq_o));
    i2cms_bus_model u_bus (.sda_oe_i(sda_oe_o), .scl_oe_i(scl_oe_o),
        .hold_sda_i(hold_sda), .hold_scl_i(hold_scl),
        .sda_o(sda_i), .scl_o(scl_i));
    // ----------------------------------------------
    // access tasks
    // ----------------------------------------------
    task automatic finish_test();
        $display("checks %0d errors %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    // hang guard, far above the hundred or so cycles needed
    always @(posedge clk_i) begin
        cyc++;
        if (cyc == 3000) begin
            fail_count++;
            finish_test();
        end
    end
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    // leading edge keeps a strobe from being set and cleared at once
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge clk_i);
        addr_i <= a;
        wdata_i <= d;
        wr_i <= 1'b1;
        @(posedge clk_i);
        wr_i <= 1'b0;
    endtask
    task automatic rd(input logic [2:0] a);
        @(posedge clk_i);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge clk_i);
        rd_i <= 1'b0;
        #1;
        rq = rdata_o;
    endtask
    task automatic wait_idle();
        n = 0;
        do begin
            rd(ADDR_CTRL2);
            n++;
        end while (rq[CTRL2_START_BIT] !== 1'b0 && n < 60);
    endtask
    task automatic irq_chk(input logic exp);
        @(posedge clk_i);
        #1;
        chk({7'h00, irq_o}, {7'h00, exp});
    endtask
    // ----------------------------------------------
    // tests
    // ----------------------------------------------
    initial begin
        repeat (5) @(posedge clk_i);
        rst_i <= 1'b0;
        for (int a = 0; a < 8; a++) begin
            rd(3'(a));
            chk(rq, 8'h00);
        end
        wr(ADDR_IRQ_EN, 8'h0f);
        wr(ADDR_RELOAD, 8'h7c);
        wr(ADDR_CTRL2, 8'h01);
        wr(ADDR_BUFFER, 8'h55);
        wr(ADDR_CTRL2, 8'h1e);
        wait_idle();
        chk(rq, 8'h00);
        chk({7'h00, sda_oe_o}, 8'h01);
        rd(ADDR_STATUS);
        chk(rq, 8'h88);
        rd(ADDR_BUFFER);
        chk(rq, 8'h00);
        rd(ADDR_IRQ_ST);
        chk(rq, 8'h0e);
        irq_chk(1'b1);
        wr(ADDR_IRQ_CLR, 8'h0f);
        rd(ADDR_IRQ_ST);
        chk(rq, 8'h00);
        irq_chk(1'b0);
        // both lines already low when the start begins
        hold_sda <= 1'b1;
        hold_scl <= 1'b1;
        wr(ADDR_CTRL2, 8'h01);
        repeat (2) @(posedge clk_i);
        rd(ADDR_IRQ_ST);
        chk(rq, 8'h01);
        rd(ADDR_CTRL2);
        chk(rq, 8'h00);
        wr(ADDR_IRQ_EN, 8'h00);
        irq_chk(1'b0);
        wr(ADDR_IRQ_EN, 8'h0f);
        irq_chk(1'b1);
        wr(ADDR_IRQ_CLR, 8'h01);
        // scl pulled low inside a long first period
        hold_sda <= 1'b0;
        hold_scl <= 1'b0;
        wr(ADDR_RELOAD, 8'h00);
        wr(ADDR_CTRL2, 8'h01);
        repeat (10) @(posedge clk_i);
        hold_scl <= 1'b1;
        repeat (3) @(posedge clk_i);
        hold_scl <= 1'b0;
        rd(ADDR_IRQ_ST);
        chk(rq, 8'h01);
        chk({7'h00, sda_oe_o}, 8'h00);
        rd(ADDR_CTRL2);
        chk(rq, 8'h00);
        // clean start with the shortest reload
        wr(ADDR_IRQ_CLR, 8'h0f);
        wr(ADDR_RELOAD, 8'h7f);
        wr(ADDR_CTRL2, 8'h01);
        wait_idle();
        chk(rq, 8'h00);
        rd(ADDR_IRQ_ST);
        chk(rq, 8'h0c);
        chk({7'h00, sda_oe_o}, 8'h01);
        // a second start while our own sda hold is still in place
        wr(ADDR_IRQ_CLR, 8'h0f);
        wr(ADDR_CTRL2, 8'h01);
        wait_idle();
        chk(rq, 8'h00);
        rd(ADDR_IRQ_ST);
        chk(rq, 8'h0c);
        chk({7'h00, sda_oe_o}, 8'h01);
        finish_test();
    end
endmodule // i2cms_start_tb
